// >>> hw/sio_map.vh
/*
  Constants for the configuration and serial register decode.
  Assumes an 8-bit I/O bus with 16-bit addresses from the host path.
*/
`ifndef SIO_MAP_VH
`define SIO_MAP_VH
`define SIO_CFG_PORT      16'h03F0
`define SIO_DATA_PORT     16'h03F1
`define SIO_KEY_FIRST     8'h51
`define SIO_KEY_SECOND    8'h23
`define SIO_KEY_EXIT      8'hBB
`define SIO_CHA_BASE_RST  16'h03F8
`define SIO_CHB_BASE_RST  16'h02F8
`define SIO_OFS_DATA      3'h0
`define SIO_OFS_IER       3'h1
`define SIO_OFS_IIR       3'h2
`define SIO_OFS_LCR       3'h3
`define SIO_OFS_MCR       3'h4
`define SIO_OFS_LSR       3'h5
`define SIO_OFS_MSR       3'h6
`define SIO_OFS_SCR       3'h7
`define SIO_DAB_BIT       7
`define SIO_CIDX_CHA_EN   8'h00
`define SIO_CIDX_CHA_IRQ  8'h01
`define SIO_CIDX_CHA_BLO  8'h02
`define SIO_CIDX_CHA_BHI  8'h03
`define SIO_CIDX_CHB_EN   8'h04
`define SIO_CIDX_CHB_IRQ  8'h05
`define SIO_CIDX_CHB_BLO  8'h06
`define SIO_CIDX_CHB_BHI  8'h07
`define SIO_IRQ_CHA_RST   4'h4
`define SIO_IRQ_CHB_RST   4'h3
`define SIO_IIR_RST       8'h01
`define SIO_LSR_RST       8'h60
`endif

// >>> hw/sio_regs.v
/*
  Configuration unlock, index/data configuration access and register
  decode of two serial channels. Assumes single-cycle I/O strobes
  synchronous to clk_sys, at most one of rd/wr per cycle.
*/
// Operation
// - Writing first then second key to config port enters configuration mode
// - In configuration mode index port selects register; data port reaches it
// - Writing exit code to config port leaves configuration mode
// - Each channel has stored enable, interrupt line and base; decode follows
// - Reset bases: channel a 3F8, channel b 2F8; changeable via configuration
// - Divisor access bit set: offsets 0 and 1 write divisor low/high
// - Divisor bit clear: offset 0 reads receive buffer, writes transmit hold
// - Divisor bit clear: offset 1 reads and writes interrupt enable
// - Offset 2 reads interrupt ident, writes fifo control, any divisor bit
// - Offsets 3 to 7: line ctrl, modem ctrl, line stat, modem stat, scratch
`timescale 1ns/1ps
`include "sio_map.vh"
module sio_regs
(
  input  wire        clk_sys,     // System clock
  input  wire        rst,         // Synchronous reset
  input  wire [15:0] io_addr,     // I/O address
  input  wire        io_wr,       // Write strobe
  input  wire        io_rd,       // Read strobe
  input  wire [7:0]  io_wdata,    // Write data
  input  wire [7:0]  rx_a,        // Channel a receive byte
  input  wire [7:0]  rx_b,        // Channel b receive byte
  input  wire [7:0]  iid_a,       // Channel a interrupt ident
  input  wire [7:0]  iid_b,       // Channel b interrupt ident
  output reg  [7:0]  io_rdata,    // Read data
  output reg         io_hit,      // Read was claimed
  output reg         cfg_mode,    // Configuration mode active
  output reg  [7:0]  tx_a,        // Channel a transmit holding
  output reg         tx_a_load,   // Channel a transmit load pulse
  output reg  [7:0]  tx_b,        // Channel b transmit holding
  output reg         tx_b_load,   // Channel b transmit load pulse
  output reg         rx_a_take,   // Channel a receive read pulse
  output reg         rx_b_take,   // Channel b receive read pulse
  output reg  [15:0] div_a,       // Channel a divisor
  output reg  [15:0] div_b,       // Channel b divisor
  output reg  [7:0]  fifo_ctl_a,  // Channel a fifo control
  output reg  [7:0]  fifo_ctl_b,  // Channel b fifo control
  output reg  [3:0]  irq_sel_a,   // Channel a interrupt line
  output reg  [3:0]  irq_sel_b    // Channel b interrupt line
);

  localparam ST_NORMAL = 2'h0;
  localparam ST_KEY1   = 2'h1;
  localparam ST_CONFIG = 2'h2;

  reg  [1:0]  state;
  reg  [7:0]  cfg_index;
  reg         en_a;
  reg         en_b;
  reg  [15:0] base_a;
  reg  [15:0] base_b;
  reg  [7:0]  ier_a;
  reg  [7:0]  ier_b;
  reg  [7:0]  lcr_a;
  reg  [7:0]  lcr_b;
  reg  [7:0]  mcr_a;
  reg  [7:0]  mcr_b;
  reg  [7:0]  lsr_a;
  reg  [7:0]  lsr_b;
  reg  [7:0]  msr_a;
  reg  [7:0]  msr_b;
  reg  [7:0]  scr_a;
  reg  [7:0]  scr_b;
  reg  [7:0]  cfg_rd;
  reg  [7:0]  next_rdata;
  reg         next_hit;

  // Eight-byte window match on the stored base
  function in_win;
    input [15:0] addr;
    input [15:0] base;
    begin
      in_win = (addr[15:3] == base[15:3]);
    end
  endfunction

  wire cfg_wr  = io_wr && (io_addr == `SIO_CFG_PORT);
  wire data_wr = io_wr && (io_addr == `SIO_DATA_PORT) && cfg_mode;
  wire data_rd = io_rd && (io_addr == `SIO_DATA_PORT) && cfg_mode;
  // Normal decode suspended in configuration mode
  wire sel_a = en_a && !cfg_mode && in_win(io_addr, base_a);
  wire sel_b = en_b && !cfg_mode && in_win(io_addr, base_b);
  wire [2:0] ofs = io_addr[2:0];
  wire dab_a = lcr_a[`SIO_DAB_BIT];
  wire dab_b = lcr_b[`SIO_DAB_BIT];

  // Unlock sequencer
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state    <= ST_NORMAL;
      cfg_mode <= 1'b0;
    end
    else if (cfg_wr)
    begin
      case (state)
        ST_NORMAL:
          if (io_wdata == `SIO_KEY_FIRST)
            state <= ST_KEY1;
        ST_KEY1:
          if (io_wdata == `SIO_KEY_SECOND)
          begin
            state    <= ST_CONFIG;
            cfg_mode <= 1'b1;
          end
          else if (io_wdata != `SIO_KEY_FIRST)
            state <= ST_NORMAL;
        ST_CONFIG:
          if (io_wdata == `SIO_KEY_EXIT)
          begin
            state    <= ST_NORMAL;
            cfg_mode <= 1'b0;
          end
        default:
        begin
          state    <= ST_NORMAL;
          cfg_mode <= 1'b0;
        end
      endcase
    end
  end

  // Configuration registers
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_index <= 8'h00;
      en_a      <= 1'b1;
      en_b      <= 1'b1;
      base_a    <= `SIO_CHA_BASE_RST;
      base_b    <= `SIO_CHB_BASE_RST;
      irq_sel_a <= `SIO_IRQ_CHA_RST;
      irq_sel_b <= `SIO_IRQ_CHB_RST;
    end
    else
    begin
      if (cfg_wr && cfg_mode && io_wdata != `SIO_KEY_EXIT)
        cfg_index <= io_wdata;
      if (data_wr)
      begin
        case (cfg_index)
          `SIO_CIDX_CHA_EN:  en_a <= io_wdata[0];
          `SIO_CIDX_CHA_IRQ: irq_sel_a <= io_wdata[3:0];
          `SIO_CIDX_CHA_BLO: base_a[7:0] <= io_wdata;
          `SIO_CIDX_CHA_BHI: base_a[15:8] <= io_wdata;
          `SIO_CIDX_CHB_EN:  en_b <= io_wdata[0];
          `SIO_CIDX_CHB_IRQ: irq_sel_b <= io_wdata[3:0];
          `SIO_CIDX_CHB_BLO: base_b[7:0] <= io_wdata;
          `SIO_CIDX_CHB_BHI: base_b[15:8] <= io_wdata;
          default: ;
        endcase
      end
    end
  end

  always @*
  begin
    case (cfg_index)
      `SIO_CIDX_CHA_EN:  cfg_rd = {7'h00, en_a};
      `SIO_CIDX_CHA_IRQ: cfg_rd = {4'h0, irq_sel_a};
      `SIO_CIDX_CHA_BLO: cfg_rd = base_a[7:0];
      `SIO_CIDX_CHA_BHI: cfg_rd = base_a[15:8];
      `SIO_CIDX_CHB_EN:  cfg_rd = {7'h00, en_b};
      `SIO_CIDX_CHB_IRQ: cfg_rd = {4'h0, irq_sel_b};
      `SIO_CIDX_CHB_BLO: cfg_rd = base_b[7:0];
      `SIO_CIDX_CHB_BHI: cfg_rd = base_b[15:8];
      default:           cfg_rd = 8'h00;
    endcase
  end

  // Channel a register writes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_a <= 8'h00; tx_a_load <= 1'b0; div_a <= 16'h0000;
      ier_a <= 8'h00; fifo_ctl_a <= 8'h00; lcr_a <= 8'h00;
      mcr_a <= 8'h00; lsr_a <= `SIO_LSR_RST; msr_a <= 8'h00;
      scr_a <= 8'h00;
    end
    else
    begin
      tx_a_load <= 1'b0;
      if (io_wr && sel_a)
      begin
        case (ofs)
          `SIO_OFS_DATA:
            if (dab_a)
              div_a[7:0] <= io_wdata;
            else
            begin
              tx_a      <= io_wdata;
              tx_a_load <= 1'b1;
            end
          `SIO_OFS_IER:
            if (dab_a)
              div_a[15:8] <= io_wdata;
            else
              ier_a <= io_wdata;
          `SIO_OFS_IIR: fifo_ctl_a <= io_wdata;
          `SIO_OFS_LCR: lcr_a <= io_wdata;
          `SIO_OFS_MCR: mcr_a <= io_wdata;
          `SIO_OFS_LSR: lsr_a <= io_wdata;
          `SIO_OFS_MSR: msr_a <= io_wdata;
          `SIO_OFS_SCR: scr_a <= io_wdata;
          default: ;
        endcase
      end
    end
  end

  // Channel b register writes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_b <= 8'h00; tx_b_load <= 1'b0; div_b <= 16'h0000;
      ier_b <= 8'h00; fifo_ctl_b <= 8'h00; lcr_b <= 8'h00;
      mcr_b <= 8'h00; lsr_b <= `SIO_LSR_RST; msr_b <= 8'h00;
      scr_b <= 8'h00;
    end
    else
    begin
      tx_b_load <= 1'b0;
      if (io_wr && sel_b)
      begin
        case (ofs)
          `SIO_OFS_DATA:
            if (dab_b)
              div_b[7:0] <= io_wdata;
            else
            begin
              tx_b      <= io_wdata;
              tx_b_load <= 1'b1;
            end
          `SIO_OFS_IER:
            if (dab_b)
              div_b[15:8] <= io_wdata;
            else
              ier_b <= io_wdata;
          `SIO_OFS_IIR: fifo_ctl_b <= io_wdata;
          `SIO_OFS_LCR: lcr_b <= io_wdata;
          `SIO_OFS_MCR: mcr_b <= io_wdata;
          `SIO_OFS_LSR: lsr_b <= io_wdata;
          `SIO_OFS_MSR: msr_b <= io_wdata;
          `SIO_OFS_SCR: scr_b <= io_wdata;
          default: ;
        endcase
      end
    end
  end

  // Read multiplexer; divisor bytes are write only
  always @*
  begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (data_rd)
    begin
      next_rdata = cfg_rd;
      next_hit   = 1'b1;
    end
    else if (io_rd && sel_a)
    begin
      next_hit = 1'b1;
      case (ofs)
        `SIO_OFS_DATA: next_rdata = dab_a ? 8'h00 : rx_a;
        `SIO_OFS_IER:  next_rdata = dab_a ? 8'h00 : ier_a;
        `SIO_OFS_IIR:  next_rdata = iid_a;
        `SIO_OFS_LCR:  next_rdata = lcr_a;
        `SIO_OFS_MCR:  next_rdata = mcr_a;
        `SIO_OFS_LSR:  next_rdata = lsr_a;
        `SIO_OFS_MSR:  next_rdata = msr_a;
        default:       next_rdata = scr_a;
      endcase
    end
    else if (io_rd && sel_b)
    begin
      next_hit = 1'b1;
      case (ofs)
        `SIO_OFS_DATA: next_rdata = dab_b ? 8'h00 : rx_b;
        `SIO_OFS_IER:  next_rdata = dab_b ? 8'h00 : ier_b;
        `SIO_OFS_IIR:  next_rdata = iid_b;
        `SIO_OFS_LCR:  next_rdata = lcr_b;
        `SIO_OFS_MCR:  next_rdata = mcr_b;
        `SIO_OFS_LSR:  next_rdata = lsr_b;
        `SIO_OFS_MSR:  next_rdata = msr_b;
        default:       next_rdata = scr_b;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      io_rdata  <= 8'h00;
      io_hit    <= 1'b0;
      rx_a_take <= 1'b0;
      rx_b_take <= 1'b0;
    end
    else
    begin
      io_rdata  <= next_rdata;
      io_hit    <= next_hit;
      rx_a_take <= io_rd && sel_a && ofs == `SIO_OFS_DATA && !dab_a;
      rx_b_take <= io_rd && sel_b && ofs == `SIO_OFS_DATA && !dab_b;
    end
  end

endmodule // sio_regs

// >>> tb/sio_host.sv
/*
  Host model issuing single-cycle I/O reads and writes.
  Assumes read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
module sio_host
(
  input  wire        clk_sys,           // Clock
  input  wire [7:0]  io_rdata,          // Read data
  input  wire        io_hit,            // Read claimed
  output reg  [15:0] io_addr  = 16'h0000, // Address
  output reg         io_wr    = 1'h0,   // Write strobe
  output reg         io_rd    = 1'h0,   // Read strobe
  output reg  [7:0]  io_wdata = 8'h00   // Write data
);
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk_sys);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'h1;
    @(posedge clk_sys);
    io_wr    <= 1'h0;
    io_addr  <= ~a;
    io_wdata <= ~d;
    @(negedge clk_sys);
  endtask
  task rd(input [15:0] a, output [7:0] d, output h);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd   <= 1'h1;
    @(posedge clk_sys);
    io_rd   <= 1'h0;
    io_addr <= ~a;
    @(negedge clk_sys);
    d = io_rdata;
    h = io_hit;
  endtask
  // Keys back to back on the config port
  task unlock;
    @(posedge clk_sys);
    io_addr  <= 16'h03F0;
    io_wdata <= 8'h51;
    io_wr    <= 1'h1;
    @(posedge clk_sys);
    io_wdata <= 8'h23;
    @(posedge clk_sys);
    io_wr    <= 1'h0;
    io_wdata <= 8'hDC;
    @(negedge clk_sys);
  endtask
  task cfg_set(input [7:0] idx, input [7:0] val);
    wr(16'h03F0, idx);
    wr(16'h03F1, val);
  endtask
endmodule // sio_host

// >>> tb/sio_regs_bench.sv
/*
  Self-checking bench for sio_regs driven through the host model.
  Assumes the reset values and index map of the design hand-over.
*/
`timescale 1ns/1ps
module sio_regs_bench;
  reg         clk_sys = 1'h0, rst = 1'h1;
  reg  [7:0]  rx_a = 8'hA5, rx_b = 8'h5A, iid_a = 8'hC1, iid_b = 8'hC2;
  wire [15:0] io_addr, div_a, div_b;
  wire [7:0]  io_wdata, io_rdata, tx_a, tx_b, fifo_ctl_a, fifo_ctl_b;
  wire        io_wr, io_rd, io_hit, cfg_mode, tx_a_load, tx_b_load;
  wire        rx_a_take, rx_b_take;
  wire [3:0]  irq_sel_a, irq_sel_b;
  integer     n_errors = 0, cmp_count = 0, cycles = 0, c, o;
  reg  [7:0]  d;
  reg         h;
  reg  [15:0] b;
  sio_host u_host (.*);
  sio_regs u_dut (.*);
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rc(input [15:0] a, input [7:0] e, input eh);
    u_host.rd(a, d, h);
    chk({8'h00, d}, {8'h00, e});
    chk({15'h0000, h}, {15'h0000, eh});
  endtask
  task stop_test;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    for (c = 0; c < 2; c = c + 1)
    begin
      b = c ? 16'h02F8 : 16'h03F8;
      for (o = 1; o < 8; o = o + 1)
        u_host.wr(b + o[15:0], {c[3:0], o[3:0]});
      for (o = 1; o < 8; o = o + 1)
        if (o != 2)
          rc(b + o[15:0], {c[3:0], o[3:0]}, 1'h1);
      chk({8'h00, c ? fifo_ctl_b : fifo_ctl_a}, {8'h00, c[3:0], 4'h2});
      rc(b + 16'h0002, c ? iid_b : iid_a, 1'h1);
      rc(b, c ? rx_b : rx_a, 1'h1);
      chk({15'h0000, c ? rx_b_take : rx_a_take}, 16'h0001);
      u_host.wr(b, 8'h3C);
      chk({15'h0000, c ? tx_b_load : tx_a_load}, 16'h0001);
      u_host.wr(b + 16'h0003, 8'h80);
      u_host.wr(b, 8'h34);
      u_host.wr(b + 16'h0001, 8'h12);
      chk(c ? div_b : div_a, 16'h1234);
      chk({8'h00, c ? tx_b : tx_a}, 16'h003C);
      rc(b + 16'h0002, c ? iid_b : iid_a, 1'h1);
      rc(b + 16'h0003, 8'h80, 1'h1);
      u_host.wr(b + 16'h0003, 8'h00);
      rc(b + 16'h0001, {c[3:0], 4'h1}, 1'h1);
    end
    u_host.wr(16'h03F0, 8'h51);
    u_host.wr(16'h03F0, 8'h77);
    u_host.wr(16'h03F0, 8'h23);
    chk({15'h0000, cfg_mode}, 16'h0000);
    u_host.unlock;
    chk({15'h0000, cfg_mode}, 16'h0001);
    rc(16'h03FF, 8'h00, 1'h0);
    u_host.cfg_set(8'h02, 8'hE8);
    u_host.cfg_set(8'h01, 8'h07);
    u_host.cfg_set(8'h04, 8'h00);
    chk({12'h000, irq_sel_a}, 16'h0007);
    chk({12'h000, irq_sel_b}, 16'h0003);
    u_host.wr(16'h03F0, 8'h02);
    rc(16'h03F1, 8'hE8, 1'h1);
    u_host.wr(16'h03F0, 8'hBB);
    chk({15'h0000, cfg_mode}, 16'h0000);
    rc(16'h03EF, 8'h07, 1'h1);
    rc(16'h03FF, 8'h00, 1'h0);
    rc(16'h02FF, 8'h00, 1'h0);
    stop_test;
  end
endmodule // sio_regs_bench

// >>> tb/sio_regs_properties.sv
/*
  Port checker for sio_regs, bound to every instance.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sio_regs_properties
(
  input wire        clk_sys, rst, io_wr, io_rd, io_hit,      // Control
  input wire [15:0] io_addr, div_a, div_b,                   // Wide
  input wire [7:0]  io_wdata, io_rdata, rx_a, rx_b, iid_a,   // Bytes
  input wire [7:0]  iid_b, tx_a, tx_b, fifo_ctl_a, fifo_ctl_b, // Bytes
  input wire        cfg_mode, tx_a_load, tx_b_load,          // Flags
  input wire        rx_a_take, rx_b_take,                    // Pulses
  input wire [3:0]  irq_sel_a, irq_sel_b                     // Irq lines
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire cfg_wr = io_wr && io_addr == 16'h03F0;
  chk_key_enter: assert property (
    !cfg_mode && cfg_wr && io_wdata == 8'h51 ##1 cfg_wr && io_wdata == 8'h23
    |=> cfg_mode) else $error("key pair did not unlock");
  chk_key_exit: assert property (
    cfg_mode && cfg_wr && io_wdata == 8'hBB |=> !cfg_mode)
    else $error("exit code ignored");
  chk_enter_cause: assert property (
    $rose(cfg_mode) |-> $past(cfg_wr && io_wdata == 8'h23))
    else $error("config mode without second key");
  chk_index_stay: assert property (
    cfg_mode && cfg_wr && io_wdata != 8'hBB |=> cfg_mode)
    else $error("index write left config mode");
  chk_decode_off: assert property (
    cfg_mode |=> !tx_a_load && !tx_b_load && !rx_a_take && !rx_b_take)
    else $error("channel decoded in config mode");
  chk_irq_cause: assert property (
    $changed(irq_sel_a) || $changed(irq_sel_b)
    |-> $past(cfg_mode && io_wr && io_addr == 16'h03F1))
    else $error("irq line changed outside config");
  chk_div_cause: assert property (
    $changed(div_a) |-> $past(io_wr && io_addr[2:1] == 2'h0) && !tx_a_load)
    else $error("divisor changed without divisor write");
  chk_tx_load: assert property (
    tx_a_load |-> tx_a == $past(io_wdata)
    && $past(io_wr && io_addr[2:0] == 3'h0))
    else $error("transmit load mismatch");
endmodule // sio_regs_properties
bind sio_regs sio_regs_properties u_chk (.*);
